// *** direct_read_ctrl.sv ***
/*
  Direct-read mode controller of a serial NOR flash: frame capture on the serial
  clock, mode and configuration state on the core clock, and a read request
  queue toward the array. Assumes the host drives the serial clock and the chip
  select, keeps the protocol setting stable across frames, and leaves at least
  four core cycles of deselect between frames.
*/
// Behaviour
// - cleared config bit plus confirm 0 enters mode
// - in mode, frames carry address only
// - confirm 1 exits and sets bit three
// - basic variant enters on confirm 0 alone
// - power-up setting starts device in mode
// - confirm is io_line0 at first dummy clock
// - confirm 0 on every read keeps mode
// - dual protocol ignores io_line1 for confirm
// - quad protocol ignores lines three to one
// - reset pin low restores power-up state
// - reset pin acts only while deselected
// - forced exit touches only the mode and bit three
// - codes 66 then 99 in separate frames
`timescale 1ns/100ps
`default_nettype none
module direct_read_ctrl
  import direct_read_pkg::*;
#(
  parameter logic [7:0] QREAD_EXT = 8'h0b,
  parameter logic [7:0] QREAD_DUAL = 8'hbb,
  parameter logic [7:0] QREAD_QUAD = 8'heb,
  parameter logic [7:0] WR_VCFG = 8'h81,
  parameter bit BASIC_VARIANT = 1'b0,
  parameter bit RESET_PIN_EN = 1'b1,
  parameter int BUF_DEPTH = 2
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  input wire logic chip_select_n_i,
  input wire logic [IO_W-1:0] io_line_i,
  input wire logic reset_pin_n_i,
  input wire logic [1:0] proto_i,
  input wire logic [15:0] nvcfg_i,
  input wire logic rd_ready_i,
  output logic rd_valid_o,
  output logic [ADDR_BITS-1:0] rd_addr_o,
  output logic rd_direct_o,
  output logic direct_read_mode_o,
  output logic [7:0] vcfg_o,
  output logic busy_o
);

  // ==========================================================================
  // Link domain: frame capture on the serial clock
  // ==========================================================================
  logic first_r;
  logic [1:0] proto_link;
  frame_cap_t cap_r;
  frame_cap_t cap_nxt;

  level_sync #(.W(2), .RST_VAL(PROTO_EXT)) u_proto_sync (
    .clk_i(sclk_i),
    .rst_i(1'b0),
    .d_i(proto_i),
    .q_o(proto_link)
  );

  // The serial clock stops between frames, so the deselect itself marks the
  // next edge as the first of a frame.
  always_ff @(posedge sclk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  always_comb begin
    logic [CNT_W-1:0] cnt;
    int base;
    int nl;
    cnt = first_r ? '0 : cap_r.clocks;
    nl = lanes(proto_link);
    base = CAP_BITS - 1 - int'(cnt) * nl;
    cap_nxt = cap_r;
    if (first_r) begin
      cap_nxt.bits = '0;
      cap_nxt.conf_norm = 1'b0;
      cap_nxt.conf_direct = 1'b0;
    end
    if (cnt < cap_clks(proto_link)) begin
      for (int k = 0; k < IO_W; k++) begin
        if (k < nl) begin
          cap_nxt.bits[base-k] = io_line_i[nl-1-k];
        end
      end
    end
    // Only line 0 is looked at here; the other lines are don't-care.
    if (cnt == cmd_clks(proto_link) + addr_clks(proto_link)) begin
      cap_nxt.conf_norm = io_line_i[0];
    end
    if (cnt == addr_clks(proto_link)) begin
      cap_nxt.conf_direct = io_line_i[0];
    end
    cap_nxt.clocks = (cnt == CNT_MAX) ? CNT_MAX : cnt + 1'b1;
  end

  always_ff @(posedge sclk_i) begin
    cap_r <= cap_nxt;
  end

  // ==========================================================================
  // Core domain: pin synchronisers and frame hand-over
  // ==========================================================================
  logic cs_s;
  logic rpin_s;
  logic cs_prev_r;
  logic frame_evt;
  logic nv_direct;
  logic buf_in_ready;
  logic pin_rst;

  level_sync #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
    .clk_i(core_clk_i),
    .rst_i(sys_rst_i),
    .d_i({chip_select_n_i, reset_pin_n_i}),
    .q_o({cs_s, rpin_s})
  );

  // The capture flops are quiet once the select is high, so the synchronised
  // rising edge qualifies a stable word.
  assign frame_evt = cs_s & ~cs_prev_r;
  assign nv_direct = nvcfg_i[NV_DR_MSB:NV_DR_LSB] != NV_DR_OFF;
  assign pin_rst = RESET_PIN_EN & ~rpin_s & cs_s;

  // ==========================================================================
  // Core domain: mode, configuration and request decode
  // ==========================================================================
  logic mode_r;
  logic mode_nxt;
  logic [7:0] vcfg_r;
  logic [7:0] vcfg_nxt;
  logic arm_r;
  logic arm_nxt;
  logic hold_r;
  logic hold_nxt;
  frame_cap_t frm_r;
  frame_cap_t frm_nxt;
  logic pend_v_r;
  logic pend_v_nxt;
  read_req_t pend_r;
  read_req_t pend_nxt;
  logic go;
  logic dr_exit;
  logic dr_enter;
  logic soft_rst;

  function automatic logic is_quick(input logic [7:0] c);
    is_quick = (c == QREAD_EXT) || (c == QREAD_DUAL) || (c == QREAD_QUAD);
  endfunction

  always_comb begin
    logic [CNT_W-1:0] cc;
    logic [CNT_W-1:0] ac;
    logic [7:0] cmd;
    cc = cmd_clks(proto_i);
    ac = addr_clks(proto_i);
    cmd = frm_r.bits[CAP_BITS-1 -: CMD_BITS];
    mode_nxt = mode_r;
    vcfg_nxt = vcfg_r;
    arm_nxt = arm_r;
    frm_nxt = frm_r;
    pend_v_nxt = pend_v_r & ~buf_in_ready;
    pend_nxt = pend_r;
    dr_exit = 1'b0;
    dr_enter = 1'b0;
    soft_rst = 1'b0;
    go = hold_r & ~pend_v_nxt;
    hold_nxt = hold_r & ~go;
    if (frame_evt) begin
      frm_nxt = cap_r;
      hold_nxt = 1'b1;
    end
    if (go && mode_r) begin
      // No command code: the frame opens with the address.
      if (frm_r.clocks > ac) begin
        if (frm_r.conf_direct) begin
          dr_exit = 1'b1;
          mode_nxt = 1'b0;
          vcfg_nxt[VCFG_DR_BIT] = 1'b1;
        end else begin
          pend_v_nxt = 1'b1;
          pend_nxt = '{addr: frm_r.bits[CAP_BITS-1 -: ADDR_BITS], direct: 1'b1};
        end
      end
    end else if (go) begin
      arm_nxt = (cmd == CMD_RST_ARM) && frm_r.clocks >= cc;
      if (cmd == CMD_RST_EXEC && arm_r && frm_r.clocks >= cc) begin
        soft_rst = 1'b1;
      end
      if (is_quick(cmd) && frm_r.clocks > cc + ac) begin
        pend_v_nxt = 1'b1;
        pend_nxt = '{addr: frm_r.bits[ADDR_BITS-1:0], direct: 1'b0};
        if (!frm_r.conf_norm && (BASIC_VARIANT || !vcfg_r[VCFG_DR_BIT])) begin
          dr_enter = 1'b1;
          mode_nxt = 1'b1;
        end
      end
      if (cmd == WR_VCFG && frm_r.clocks >= cc + cc) begin
        vcfg_nxt = frm_r.bits[ADDR_BITS-1 -: CMD_BITS];
      end
    end
    if (soft_rst || pin_rst) begin
      mode_nxt = nv_direct;
      vcfg_nxt = VCFG_RESET;
      vcfg_nxt[VCFG_DR_BIT] = ~nv_direct;
      arm_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mode_r <= nv_direct;
      vcfg_r <= {VCFG_RESET[7:VCFG_DR_BIT+1], ~nv_direct, VCFG_RESET[VCFG_DR_BIT-1:0]};
      arm_r <= 1'b0;
      hold_r <= 1'b0;
      pend_v_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end else begin
      mode_r <= mode_nxt;
      vcfg_r <= vcfg_nxt;
      arm_r <= arm_nxt;
      hold_r <= hold_nxt;
      pend_v_r <= pend_v_nxt;
      cs_prev_r <= cs_s;
    end
    frm_r <= frm_nxt;
    pend_r <= pend_nxt;
  end

  // ==========================================================================
  // Request queue toward the array
  // ==========================================================================
  logic [$bits(read_req_t)-1:0] buf_out;

  // A stalled drain backs up into the pending slot and then holds decode.
  req_buffer #(.W($bits(read_req_t)), .DEPTH(BUF_DEPTH)) u_req_buf (
    .clk_i(core_clk_i),
    .rst_i(sys_rst_i),
    .in_valid_i(pend_v_r),
    .in_ready_o(buf_in_ready),
    .in_data_i(pend_r),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o(buf_out)
  );

  assign rd_addr_o = buf_out[ADDR_BITS:1];
  assign rd_direct_o = buf_out[0];
  assign direct_read_mode_o = mode_r;
  assign vcfg_o = vcfg_r;
  assign busy_o = hold_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_enter;
    go && !mode_r && is_quick(frm_r.bits[CAP_BITS-1 -: CMD_BITS]) && !frm_r.conf_norm &&
      !vcfg_r[VCFG_DR_BIT] && frm_r.clocks > cmd_clks(proto_i) + addr_clks(proto_i) &&
      !pin_rst |=> mode_r;
  endproperty
  a_enter: assert property (p_enter) else $error("mode not entered");

  property p_exit;
    dr_exit && !pin_rst |=> !mode_r && vcfg_r[VCFG_DR_BIT] && $stable(vcfg_r[2:0]);
  endproperty
  a_exit: assert property (p_exit) else $error("exit wrong");

  property p_basic;
    go && !mode_r && BASIC_VARIANT && dr_enter && !pin_rst |=> mode_r;
  endproperty
  a_basic: assert property (p_basic) else $error("basic entry failed");

  property p_powerup;
    disable iff (1'b0) sys_rst_i ##1 !sys_rst_i |-> mode_r == nv_direct;
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up mode wrong");

  property p_persist;
    mode_r && !dr_exit && !pin_rst && !soft_rst |=> mode_r;
  endproperty
  a_persist: assert property (p_persist) else $error("mode dropped");

  property p_pin;
    pin_rst |=> mode_r == nv_direct && vcfg_r[VCFG_DR_BIT] == !nv_direct;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset ignored");

  property p_pin_selected;
    !cs_s && !go |=> $stable(mode_r);
  endproperty
  a_pin_selected: assert property (p_pin_selected) else $error("reset while selected");

  property p_direct_push;
    go && mode_r && !frm_r.conf_direct && frm_r.clocks > addr_clks(proto_i)
      |=> pend_v_r && pend_r.direct && pend_r.addr == $past(frm_r.bits[CAP_BITS-1 -: ADDR_BITS]);
  endproperty
  a_direct_push: assert property (p_direct_push) else $error("address lost");

  property p_soft;
    soft_rst |=> !arm_r ##0 mode_r == nv_direct;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset failed");

  property p_conf_sample;
    @(posedge sclk_i) disable iff (chip_select_n_i)
      !first_r && cap_r.clocks == addr_clks(proto_link) |=> cap_r.conf_direct == $past(io_line_i[0]);
  endproperty
  a_conf_sample: assert property (p_conf_sample) else $error("confirm mis-sampled");

  c_enter: cover property (dr_enter);
  c_exit: cover property (dr_exit);
  c_stall: cover property (pend_v_r && !buf_in_ready ##1 hold_r);
  c_soft: cover property (soft_rst);

endmodule
`default_nettype wire

// *** direct_read_pkg.sv ***
/*
  Shared constants, carrier types and clock-count helpers for the direct-read
  mode block of a serial NOR flash. Assumes the importing modules use the
  protocol encodings and widths declared here.
*/
package direct_read_pkg;

  // ==========================================================================
  // Widths and frame layout
  // ==========================================================================
  localparam int IO_W = 4;
  localparam int CMD_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int CAP_BITS = 32;
  localparam int CNT_W = 8;

  // ==========================================================================
  // Protocol encodings
  // ==========================================================================
  localparam logic [1:0] PROTO_EXT = 2'h0;
  localparam logic [1:0] PROTO_DUAL = 2'h1;
  localparam logic [1:0] PROTO_QUAD = 2'h2;

  // ==========================================================================
  // Command codes and configuration fields
  // ==========================================================================
  localparam logic [7:0] CMD_RST_ARM = 8'h66;
  localparam logic [7:0] CMD_RST_EXEC = 8'h99;
  localparam int VCFG_DR_BIT = 3;
  localparam logic [7:0] VCFG_RESET = 8'hff;
  localparam int NV_DR_LSB = 9;
  localparam int NV_DR_MSB = 11;
  localparam logic [2:0] NV_DR_OFF = 3'h7;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic direct;
  } read_req_t;

  typedef struct packed {
    logic [CAP_BITS-1:0] bits;
    logic [CNT_W-1:0] clocks;
    logic conf_norm;
    logic conf_direct;
  } frame_cap_t;

  // ==========================================================================
  // Clock counts per protocol
  // ==========================================================================
  function automatic int lanes(input logic [1:0] proto);
    case (proto)
      PROTO_DUAL: lanes = 2;
      PROTO_QUAD: lanes = 4;
      default: lanes = 1;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] cmd_clks(input logic [1:0] proto);
    cmd_clks = CNT_W'(CMD_BITS / lanes(proto));
  endfunction

  function automatic logic [CNT_W-1:0] addr_clks(input logic [1:0] proto);
    addr_clks = CNT_W'(ADDR_BITS / lanes(proto));
  endfunction

  function automatic logic [CNT_W-1:0] cap_clks(input logic [1:0] proto);
    cap_clks = CNT_W'(CAP_BITS / lanes(proto));
  endfunction

endpackage

// *** level_sync.sv ***
/*
  Two-flop synchroniser for slowly changing levels. Assumes the input is
  quasi-static relative to the destination clock.
*/
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = rst_i ? RST_VAL : d_i;
    q_nxt = rst_i ? RST_VAL : meta_r;
  end

  always_ff @(posedge clk_i) begin
    meta_r <= meta_nxt;
    q_r <= q_nxt;
  end

  assign q_o = q_r;

endmodule
`default_nettype wire

// *** req_buffer.sv ***
/*
  Small shifting buffer with valid/ready on both sides. The head entry and its
  valid bit are flops, so the drain side sees registered outputs. Assumes one
  clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module req_buffer #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] vld_nxt;

  always_comb begin
    logic pop;
    logic placed;
    pop = vld_r[0] & out_ready_i;
    placed = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && i < DEPTH - 1) begin
        mem_nxt[i] = mem_r[i+1];
        vld_nxt[i] = vld_r[i+1];
      end else if (pop) begin
        mem_nxt[i] = mem_r[i];
        vld_nxt[i] = 1'b0;
      end else begin
        mem_nxt[i] = mem_r[i];
        vld_nxt[i] = vld_r[i];
      end
    end
    for (int i = 0; i < DEPTH; i++) begin
      if (in_valid_i && !vld_r[DEPTH-1] && !vld_nxt[i] && !placed) begin
        mem_nxt[i] = in_data_i;
        vld_nxt[i] = 1'b1;
        placed = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_r[i] <= mem_nxt[i];
    end
    if (rst_i) begin
      vld_r <= '0;
    end else begin
      vld_r <= vld_nxt;
    end
  end

  // Full is judged on the registered state only, so a pop never widens ready.
  assign in_ready_o = ~vld_r[DEPTH-1];
  assign out_valid_o = vld_r[0];
  assign out_data_o = mem_r[0];

endmodule
`default_nettype wire

// *** spi_host_model.sv ***
/*
  Host controller model that drives frames onto the serial link of the
  direct-read block. Assumes the caller leaves the deselect gap between frames.
*/
`timescale 1ns/100ps
`default_nettype none
module spi_host_model
  import direct_read_pkg::*;
(
  output logic sclk_o,
  output logic chip_select_n_o,
  output logic [IO_W-1:0] io_line_o
);
  // ==========================================================================
  // Frame driver
  // ==========================================================================
  initial begin
    sclk_o = 1'b0;
    chip_select_n_o = 1'b1;
    io_line_o = 4'h5;
  end

  // The clock stands low between frames, and released lines show the inverse
  // of their last value so that a stale level can never pass for fresh data.
  task automatic frame(input logic [1:0] proto, input logic [63:0] s, input int n);
    int l;
    logic [IO_W-1:0] nxt;
    l = (proto == PROTO_QUAD) ? 4 : (proto == PROTO_DUAL) ? 2 : 1;
    #7;
    chip_select_n_o = 1'b0;
    for (int k = 0; k < n; k++) begin
      nxt = ~io_line_o;
      for (int j = 0; j < l; j++) begin
        nxt[j] = s[64 - (k + 1) * l + j];
      end
      io_line_o = nxt;
      #15 sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
    end
    #15 chip_select_n_o = 1'b1;
    io_line_o = ~io_line_o;
  endtask
endmodule
`default_nettype wire

// *** tb_direct_read_ctrl.sv ***
/*
  Self-checking testbench for the direct-read mode controller. Assumes the
  host model drives the link and the bench drives the core-side inputs.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_direct_read_ctrl;
  import direct_read_pkg::*;
  logic core_clk_i, sys_rst_i, sclk, cs_n, pin_n, rd_ready, rd_valid, rd_direct, mode, busy;
  logic [IO_W-1:0] io;
  logic [1:0] proto;
  logic [15:0] nvcfg;
  logic [23:0] rd_addr;
  logic [7:0] vcfg;
  int errors, cmp_count;

  spi_host_model i_spi_host_model (.sclk_o(sclk), .chip_select_n_o(cs_n), .io_line_o(io));

  direct_read_ctrl i_direct_read_ctrl (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk),
    .chip_select_n_i(cs_n), .io_line_i(io), .reset_pin_n_i(pin_n), .proto_i(proto),
    .nvcfg_i(nvcfg), .rd_ready_i(rd_ready), .rd_valid_o(rd_valid), .rd_addr_o(rd_addr),
    .rd_direct_o(rd_direct), .direct_read_mode_o(mode), .vcfg_o(vcfg), .busy_o(busy));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic final_report;
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic int lanes_of(input logic [1:0] p);
    return (p == PROTO_QUAD) ? 4 : (p == PROTO_DUAL) ? 2 : 1;
  endfunction

  function automatic logic [7:0] qread_of(input logic [1:0] p);
    return (p == PROTO_QUAD) ? i_direct_read_ctrl.QREAD_QUAD :
           (p == PROTO_DUAL) ? i_direct_read_ctrl.QREAD_DUAL : i_direct_read_ctrl.QREAD_EXT;
  endfunction

  // Decode lands about four core edges after deselect; eight also covers the gap.
  task automatic frame(input logic [63:0] s, input int n);
    i_spi_host_model.frame(proto, s, n);
    repeat (8) @(negedge core_clk_i);
  endtask

  task automatic rd(input bit cmd, input logic [23:0] a, input logic conf);
    int l;
    logic [63:0] s;
    l = lanes_of(proto);
    if (cmd) begin
      s = {qread_of(proto), a, 32'hffff_ffff};
      s[32 - l] = conf;
      frame(s, 32 / l + 2);
    end else begin
      s = {a, 40'hff_ffff_ffff};
      s[40 - l] = conf;
      frame(s, 24 / l + 2);
    end
  endtask

  task automatic state(input logic m, input logic [7:0] v);
    chk("mode", {31'h0, m}, {31'h0, mode});
    chk("vcfg", {24'h0, v}, {24'h0, vcfg});
  endtask

  task automatic pop(input logic [23:0] a, input logic d);
    for (int t = 0; t < 50 && rd_valid !== 1'b1; t++) begin
      @(negedge core_clk_i);
    end
    chk("rd_addr", {7'h0, a, d}, {7'h0, rd_addr, rd_direct});
    rd_ready = 1'b1;
    @(negedge core_clk_i);
    rd_ready = 1'b0;
  endtask

  task automatic do_reset(input logic [15:0] nv, input logic [1:0] p);
    nvcfg = nv;
    proto = p;
    sys_rst_i = 1'b1;
    // Two link clocks under reset carry the new protocol across its synchroniser.
    i_spi_host_model.frame(p, 64'h0, 2);
    repeat (4) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    @(negedge core_clk_i);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_enter_forced(input logic [1:0] p);
    do_reset(16'h0e00, p);
    state(1'b0, 8'hff);
    chk("busy", 32'h0, {31'h0, busy});
    rd(1'b1, 24'h12_3456, 1'b0);
    state(1'b0, 8'hff);
    pop(24'h12_3456, 1'b0);
    frame({i_direct_read_ctrl.WR_VCFG, 8'hf7, 48'h0}, 16 / lanes_of(p));
    rd(1'b1, 24'h65_4321, 1'b0);
    state(1'b1, 8'hf7);
    pop(24'h65_4321, 1'b0);
    rd(1'b0, 24'hab_cdef, 1'b0);
    chk("mode", 32'h1, {31'h0, mode});
    pop(24'hab_cdef, 1'b1);
    frame(64'hffff_ffff_ffff_ffff, (p == PROTO_QUAD) ? 7 : (p == PROTO_DUAL) ? 13 : 25);
    state(1'b0, 8'hff);
    chk("rd_valid", 32'h0, {31'h0, rd_valid});
  endtask

  task automatic t_powerup_pin_sw;
    do_reset(16'h0000, PROTO_QUAD);
    state(1'b1, 8'hf7);
    rd(1'b0, 24'h00_0010, 1'b0);
    pop(24'h00_0010, 1'b1);
    rd(1'b0, 24'h00_0020, 1'b1);
    state(1'b0, 8'hff);
    chk("rd_valid", 32'h0, {31'h0, rd_valid});
    pin_n = 1'b0;
    repeat (5) @(negedge core_clk_i);
    pin_n = 1'b1;
    repeat (4) @(negedge core_clk_i);
    state(1'b1, 8'hf7);
    nvcfg = 16'h0e00;
    frame(64'hffff_ffff_ffff_ffff, 7);
    frame({i_direct_read_ctrl.WR_VCFG, 8'hf7, 48'h0}, 4);
    frame({CMD_RST_ARM, 56'h0}, 2);
    frame({CMD_RST_EXEC, 56'h0}, 2);
    state(1'b0, 8'hff);
  endtask

  task automatic t_buffer;
    do_reset(16'h0e00, PROTO_EXT);
    for (int i = 1; i <= 4; i++) begin
      rd(1'b1, 24'(i), 1'b1);
    end
    chk("busy", 32'h1, {31'h0, busy});
    chk("mode", 32'h0, {31'h0, mode});
    for (int i = 1; i <= 4; i++) begin
      pop(24'(i), 1'b0);
    end
    repeat (4) @(negedge core_clk_i);
    chk("busy", 32'h0, {31'h0, busy});
    chk("rd_valid", 32'h0, {31'h0, rd_valid});
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    errors = 0;
    cmp_count = 0;
    sys_rst_i = 1'b1;
    pin_n = 1'b1;
    rd_ready = 1'b0;
    proto = PROTO_EXT;
    nvcfg = 16'h0e00;
    @(negedge core_clk_i);
    t_enter_forced(PROTO_EXT);
    t_enter_forced(PROTO_DUAL);
    t_enter_forced(PROTO_QUAD);
    t_powerup_pin_sw;
    t_buffer;
    final_report;
  end

  initial begin
    #500000;
    errors++;
    final_report;
  end
endmodule
`default_nettype wire
